// ### src/occs_clock_switch.sv
// How it works
// - Mid enable bit starts mid oscillator
// - Select bit moves main clock to mid while mid enable bit is set
// - Status bit rises once mid drives clock
// - Halt bit stops high oscillator
module occs_clock_switch
    import occs_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = MID_OSC_STAB_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Oscillator controls
    output logic high_osc_run,
    output logic mid_osc_run,
    output logic x1_osc_run,
    output logic xt1_osc_run,
    // Clock multiplexer
    output logic mux_sel_mid,
    input wire logic mux_ack_mid
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic x1_osc_halt;
        logic xt1_osc_halt;
        logic mid_osc_enable;
        logic high_osc_halt;
        logic main_onchip_osc_sel;
        logic main_sys_clk_sel;
        logic cpu_clk_source_sel;
        logic [STAB_CNT_W-1:0] stab_cnt;
        logic mid_stable;
        logic early_select;
        logic [DATA_W-1:0] rdata;
    } occs_regs_s;

    occs_regs_s r_q;
    occs_regs_s r_d;

    localparam logic [STAB_CNT_W-1:0] STAB_LAST =
        STAB_CNT_W'(STAB_CYCLES - 1);

    occs_sw_if swi ();

    logic wr_run;
    logic wr_sel;
    logic wr_stat;
    logic sel_set;
    logic [DATA_W-1:0] run_view;
    logic [DATA_W-1:0] sel_view;
    logic [DATA_W-1:0] stat_view;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    assign wr_run = reg_wr && (reg_addr == OSC_RUN_CONTROL_ADDR);
    assign wr_sel = reg_wr && (reg_addr == SYSCLK_SOURCE_SELECT_ADDR);
    assign wr_stat = reg_wr && (reg_addr == SWITCH_STATUS_ADDR);
    assign sel_set = wr_sel && reg_wdata[MAIN_ONCHIP_OSC_SEL_BIT];

    // ****************************************************************
    // Read views
    // ****************************************************************
    always_comb begin
        run_view = '0;
        run_view[X1_OSC_HALT_BIT] = r_q.x1_osc_halt;
        run_view[XT1_OSC_HALT_BIT] = r_q.xt1_osc_halt;
        run_view[MID_OSC_ENABLE_BIT] = r_q.mid_osc_enable;
        run_view[HIGH_OSC_HALT_BIT] = r_q.high_osc_halt;
    end

    // Status bits of sources outside this block read as zero
    always_comb begin
        sel_view = '0;
        sel_view[CPU_CLK_SOURCE_SEL_BIT] = r_q.cpu_clk_source_sel;
        sel_view[MAIN_SYS_CLK_SEL_BIT] = r_q.main_sys_clk_sel;
        sel_view[MAIN_ONCHIP_OSC_SEL_BIT] = r_q.main_onchip_osc_sel;
        sel_view[MAIN_ONCHIP_OSC_STATUS_BIT] = swi.on_mid;
    end

    always_comb begin
        stat_view = '0;
        stat_view[MID_STABLE_BIT] = r_q.mid_stable;
        stat_view[EARLY_SELECT_BIT] = r_q.early_select;
        stat_view[SWITCH_BUSY_BIT] = swi.busy;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;

        // Oscillator run control
        if (wr_run) begin
            r_d.x1_osc_halt = reg_wdata[X1_OSC_HALT_BIT];
            r_d.xt1_osc_halt = reg_wdata[XT1_OSC_HALT_BIT];
            r_d.mid_osc_enable = reg_wdata[MID_OSC_ENABLE_BIT];
            r_d.high_osc_halt = reg_wdata[HIGH_OSC_HALT_BIT];
        end

        // Source selection
        if (wr_sel) begin
            r_d.main_onchip_osc_sel = reg_wdata[MAIN_ONCHIP_OSC_SEL_BIT];
            r_d.main_sys_clk_sel = reg_wdata[MAIN_SYS_CLK_SEL_BIT];
            r_d.cpu_clk_source_sel = reg_wdata[CPU_CLK_SOURCE_SEL_BIT];
        end

        // Stabilisation timer restarts whenever mid is off
        if (!r_q.mid_osc_enable) begin
            r_d.stab_cnt = '0;
            r_d.mid_stable = 1'b0;
        end else if (!r_q.mid_stable) begin
            if (r_q.stab_cnt == STAB_LAST) begin
                r_d.mid_stable = 1'b1;
            end else begin
                r_d.stab_cnt = r_q.stab_cnt + STAB_CNT_W'(1);
            end
        end

        // Sticky flag, write one to clear, a new event wins
        if (wr_stat && reg_wdata[EARLY_SELECT_BIT]) begin
            r_d.early_select = 1'b0;
        end
        if (sel_set && !r_q.mid_stable) begin
            r_d.early_select = 1'b1;
        end

        // Read data valid one cycle after the strobe
        r_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OSC_RUN_CONTROL_ADDR: r_d.rdata = run_view;
                SYSCLK_SOURCE_SELECT_ADDR: r_d.rdata = sel_view;
                SWITCH_STATUS_ADDR: r_d.rdata = stat_view;
                default: r_d.rdata = '0;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q.x1_osc_halt <= OSC_RUN_CONTROL_RESET[X1_OSC_HALT_BIT];
            r_q.xt1_osc_halt <= OSC_RUN_CONTROL_RESET[XT1_OSC_HALT_BIT];
            r_q.mid_osc_enable <=
                OSC_RUN_CONTROL_RESET[MID_OSC_ENABLE_BIT];
            r_q.high_osc_halt <= OSC_RUN_CONTROL_RESET[HIGH_OSC_HALT_BIT];
            r_q.main_onchip_osc_sel <=
                SYSCLK_SOURCE_SELECT_RESET[MAIN_ONCHIP_OSC_SEL_BIT];
            r_q.main_sys_clk_sel <=
                SYSCLK_SOURCE_SELECT_RESET[MAIN_SYS_CLK_SEL_BIT];
            r_q.cpu_clk_source_sel <=
                SYSCLK_SOURCE_SELECT_RESET[CPU_CLK_SOURCE_SEL_BIT];
            r_q.stab_cnt <= '0;
            r_q.mid_stable <= 1'b0;
            r_q.early_select <= 1'b0;
            r_q.rdata <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Source switch
    // ****************************************************************
    // Mid is wanted only while its oscillator runs
    assign swi.want_mid = r_q.main_onchip_osc_sel
                          && r_q.mid_osc_enable;
    assign swi.high_running = !r_q.high_osc_halt;

    occs_source_switch u_switch (
        .clk(clk),
        .rst(rst),
        .sw(swi.sw),
        .mux_sel_mid(mux_sel_mid),
        .mux_ack_mid(mux_ack_mid)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = r_q.rdata;
    assign high_osc_run = !r_q.high_osc_halt;
    assign mid_osc_run = r_q.mid_osc_enable;
    assign x1_osc_run = !r_q.x1_osc_halt;
    assign xt1_osc_run = !r_q.xt1_osc_halt;

endmodule

// ### src/occs_pkg.sv
package occs_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam logic [1:0] OSC_RUN_CONTROL_ADDR = 2'h0;
    localparam logic [1:0] SYSCLK_SOURCE_SELECT_ADDR = 2'h1;
    localparam logic [1:0] SWITCH_STATUS_ADDR = 2'h2;

    // ****************************************************************
    // Oscillator run-control fields
    // ****************************************************************
    localparam int unsigned HIGH_OSC_HALT_BIT = 0;
    localparam int unsigned MID_OSC_ENABLE_BIT = 1;
    localparam int unsigned XT1_OSC_HALT_BIT = 6;
    localparam int unsigned X1_OSC_HALT_BIT = 7;
    localparam logic [7:0] OSC_RUN_CONTROL_RESET = 8'hc0;

    // ****************************************************************
    // Source select fields
    // ****************************************************************
    localparam int unsigned MAIN_ONCHIP_OSC_SEL_BIT = 0;
    localparam int unsigned MAIN_ONCHIP_OSC_STATUS_BIT = 1;
    localparam int unsigned MAIN_SYS_CLK_SEL_BIT = 4;
    localparam int unsigned MAIN_SYS_CLK_STATUS_BIT = 5;
    localparam int unsigned CPU_CLK_SOURCE_SEL_BIT = 6;
    localparam int unsigned CPU_CLK_SOURCE_STATUS_BIT = 7;
    localparam logic [7:0] SYSCLK_SOURCE_SELECT_RESET = 8'h00;

    // ****************************************************************
    // Switch status fields
    // ****************************************************************
    localparam int unsigned MID_STABLE_BIT = 0;
    localparam int unsigned EARLY_SELECT_BIT = 1;
    localparam int unsigned SWITCH_BUSY_BIT = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MID_OSC_STAB_NS = 4000;
    localparam int unsigned MID_OSC_STAB_CYCLES =
        (MID_OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STAB_CNT_W = 8;

    // ****************************************************************
    // Source switch states
    // ****************************************************************
    typedef enum logic [1:0] {
        SW_ON_HIGH,
        SW_TO_MID,
        SW_ON_MID,
        SW_TO_HIGH
    } occs_sw_state_e;

endpackage

// ### src/occs_sw_if.sv
interface occs_sw_if;
    logic want_mid;
    logic high_running;
    logic on_mid;
    logic busy;

    modport ctrl (output want_mid, output high_running,
                  input on_mid, input busy);
    modport sw (input want_mid, input high_running,
                output on_mid, output busy);
endinterface

// ### src/occs_source_switch.sv
module occs_source_switch
    import occs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request and status toward the register block
    occs_sw_if.sw sw,
    // Clock multiplexer
    output logic mux_sel_mid,
    input wire logic mux_ack_mid
);

    typedef struct packed {
        logic ack_meta;
        logic ack_sync;
        logic sel_mid;
        occs_sw_state_e st;
    } occs_sw_s;

    occs_sw_s r_q;
    occs_sw_s r_d;

    // ****************************************************************
    // Handover sequence to the clock multiplexer
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        r_d.ack_meta = mux_ack_mid;
        r_d.ack_sync = r_q.ack_meta;
        case (r_q.st)
            SW_ON_HIGH: begin
                if (sw.want_mid) begin
                    r_d.sel_mid = 1'b1;
                    r_d.st = SW_TO_MID;
                end
            end
            SW_TO_MID: begin
                // Wait until the mux has really moved over
                if (r_q.ack_sync) begin
                    r_d.st = SW_ON_MID;
                end
            end
            SW_ON_MID: begin
                // Going back needs a running high-speed source
                if (!sw.want_mid && sw.high_running) begin
                    r_d.sel_mid = 1'b0;
                    r_d.st = SW_TO_HIGH;
                end
            end
            SW_TO_HIGH: begin
                if (!r_q.ack_sync) begin
                    r_d.st = SW_ON_HIGH;
                end
            end
            default: begin
                r_d.st = SW_ON_HIGH;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '{ack_meta: 1'b0, ack_sync: 1'b0, sel_mid: 1'b0,
                     st: SW_ON_HIGH};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    assign mux_sel_mid = r_q.sel_mid;
    assign sw.on_mid = (r_q.st == SW_ON_MID) || (r_q.st == SW_TO_HIGH);
    assign sw.busy = (r_q.st == SW_TO_MID) || (r_q.st == SW_TO_HIGH);

endmodule

// ### verif/occs_clock_switch_checker.sv
module occs_clock_switch_checker
    import occs_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = MID_OSC_STAB_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Oscillators and mux
    input wire logic high_osc_run,
    input wire logic mid_osc_run,
    input wire logic mux_sel_mid,
    input wire logic mux_ack_mid
);
    // ****************************************************************
    // Switch sequence checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Decoded accesses
    logic wr_run;
    logic wr_sel;
    logic rd_sel;
    assign wr_run = reg_wr && reg_addr == OSC_RUN_CONTROL_ADDR;
    assign wr_sel = reg_wr && reg_addr == SYSCLK_SOURCE_SELECT_ADDR;
    assign rd_sel = reg_rd && reg_addr == SYSCLK_SOURCE_SELECT_ADDR;

    chk_mid_osc_start: assert property (
        wr_run |=> mid_osc_run == $past(reg_wdata[MID_OSC_ENABLE_BIT]))
        else $error("mid oscillator run does not follow enable");
    chk_high_osc_halt: assert property (
        wr_run |=> high_osc_run != $past(reg_wdata[HIGH_OSC_HALT_BIT]))
        else $error("high oscillator run does not follow halt");
    chk_mux_select_mid: assert property (
        (!mux_ack_mid)[*3] ##0 (wr_sel && reg_wdata[MAIN_ONCHIP_OSC_SEL_BIT]
        && mid_osc_run && !mux_sel_mid) |-> ##2 mux_sel_mid)
        else $error("mux select did not follow source select");
    chk_status_waits: assert property (
        (!mux_ack_mid)[*5] ##0 rd_sel
        |=> !reg_rdata[MAIN_ONCHIP_OSC_STATUS_BIT])
        else $error("status set before mid drives clock");
    chk_status_set: assert property (
        (mux_sel_mid && mux_ack_mid)[*5] ##0 rd_sel
        |=> reg_rdata[MAIN_ONCHIP_OSC_STATUS_BIT])
        else $error("status not set while mid drives clock");
    chk_mux_release: assert property (
        $fell(mux_sel_mid) |-> high_osc_run)
        else $error("mux left mid while high oscillator halted");
endmodule

bind occs_clock_switch occs_clock_switch_checker #(
    .STAB_CYCLES(STAB_CYCLES)
) chk_i (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .high_osc_run(high_osc_run),
    .mid_osc_run(mid_osc_run),
    .mux_sel_mid(mux_sel_mid),
    .mux_ack_mid(mux_ack_mid)
);

// ### verif/occs_clock_switch_bench.sv
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end

module occs_clock_switch_bench
    import occs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Bench signals
    // ****************************************************************
    localparam int unsigned STAB = 4;
    logic clk, rst, reg_wr, reg_rd;
    logic mux_ack_mid = 1'b0;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [7:0] sel_sh = 8'h00;
    logic high_osc_run, mid_osc_run, x1_osc_run, xt1_osc_run, mux_sel_mid;
    int bad_count = 0;
    int checks_done = 0;

    occs_clock_switch #(.STAB_CYCLES(STAB)) uut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .high_osc_run(high_osc_run), .mid_osc_run(mid_osc_run),
        .x1_osc_run(x1_osc_run), .xt1_osc_run(xt1_osc_run),
        .mux_sel_mid(mux_sel_mid), .mux_ack_mid(mux_ack_mid));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Glitch-free mux: ack follows select seven edges late
    always @(posedge clk) begin
        sel_sh <= {sel_sh[6:0], mux_sel_mid};
        mux_ack_mid <= sel_sh[5];
    end

    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read, masked compare in the answer cycle
    task automatic rd(input logic [1:0] a, input logic [7:0] m, e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata & m, e)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(5000 * 50);
        bad_count++;
        print_verdict();
    end

    // Test sequence
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        do_reset();
        #1;
        `CHK({high_osc_run, mid_osc_run, mux_sel_mid}, 3'b100)
        `CHK({x1_osc_run, xt1_osc_run}, 2'b00)
        rd(OSC_RUN_CONTROL_ADDR, 8'hff, OSC_RUN_CONTROL_RESET);
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'hff, 8'h00);
        rd(OSC_RUN_CONTROL_ADDR, 8'hff, 8'hc0);
        wr(SYSCLK_SOURCE_SELECT_ADDR, 8'hf0);
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h50);
        wr(SYSCLK_SOURCE_SELECT_ADDR, 8'h00);
        $display("test reset and map done");
        wr(OSC_RUN_CONTROL_ADDR, 8'h02);
        #1;
        `CHK({high_osc_run, mid_osc_run, x1_osc_run, xt1_osc_run}, 4'hf)
        repeat (STAB + 2) @(posedge clk);
        rd(SWITCH_STATUS_ADDR, 8'h03, 8'h01);
        wr(SYSCLK_SOURCE_SELECT_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        `CHK(mux_sel_mid, 1'b1)
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h01);
        rd(SWITCH_STATUS_ADDR, 8'h04, 8'h04);
        repeat (12) @(posedge clk);
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h03);
        wr(OSC_RUN_CONTROL_ADDR, 8'h03);
        #1;
        `CHK(high_osc_run, 1'b0)
        $display("test switch to mid done");
        wr(SYSCLK_SOURCE_SELECT_ADDR, 8'h00);
        repeat (8) @(posedge clk);
        #1;
        `CHK(mux_sel_mid, 1'b1)
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h02);
        wr(OSC_RUN_CONTROL_ADDR, 8'h02);
        repeat (20) @(posedge clk);
        #1;
        `CHK(mux_sel_mid, 1'b0)
        rd(SYSCLK_SOURCE_SELECT_ADDR, 8'hff, 8'h00);
        $display("test return to high done");
        do_reset();
        wr(OSC_RUN_CONTROL_ADDR, 8'h02);
        wr(SYSCLK_SOURCE_SELECT_ADDR, 8'h01);
        rd(SWITCH_STATUS_ADDR, 8'h02, 8'h02);
        wr(SWITCH_STATUS_ADDR, 8'h02);
        rd(SWITCH_STATUS_ADDR, 8'h02, 8'h00);
        $display("test early select done");
        print_verdict();
    end
endmodule
